// File: core/hsp_defs.svh
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
// clock rate in hz and serial bit rate (not documented, plain default)
`define HSP_CLK_HZ        50000000
`define HSP_BAUD          1000000
// clock cycles per serial bit, derived from the two rates
`define HSP_BIT_CYC       (`HSP_CLK_HZ / `HSP_BAUD)
// data bits per character
`define HSP_DATA_BITS     8
// infrared pulse length in clock cycles: three sixteenths of a bit
`define HSP_IR_CYC        ((`HSP_BIT_CYC * 3) / 16)

// ----------------------------------------------------------------------------
// reset values of the lines
// ----------------------------------------------------------------------------
`define HSP_LINE_IDLE     1'b1
// active-low handshake levels
`define HSP_HS_ASSERT     1'b0
`define HSP_HS_DEASSERT   1'b1

`endif

// File: core/hsp_device_end.sv
`timescale 1ns/1ps
// How it works
// - full duplex serial, flow control, rs485, infrared
// - request is output, permit input, active low
// - idle transmit line rests high
// - low handshake level means asserted
// - data paths are crossed between ends
// - host stops sending when request deasserted
// - host must not loop handshake lines
// - two-entry queue of received characters, transmit takes one character at a time
module hsp_device_end
    import hsp_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    // link
    hsp_link_if.device      link,
    // modes
    input  wire logic       i_ir_mode,
    output logic            o_rs485_de,
    // user streams
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    input  wire logic       i_rx_ready,
    output logic            o_rx_overrun
);
    // crossed wiring: device receives host transmit
    hsp_port_core u_core (
        .i_ref_clk    (i_ref_clk),
        .i_rst_b      (i_rst_b),
        .i_ce         (i_ce),
        .i_ir_mode    (i_ir_mode),
        .i_rx_line    (link.host_tx),
        .i_permit_n   (link.host_req_n),
        .o_tx_line    (link.dev_tx),
        .o_tx_drive   (o_rs485_de),
        .o_req_n      (link.dev_req_n),
        .i_tx_valid   (i_tx_valid),
        .i_tx_data    (i_tx_data),
        .o_tx_ready   (o_tx_ready),
        .o_rx_valid   (o_rx_valid),
        .o_rx_data    (o_rx_data),
        .i_rx_ready   (i_rx_ready),
        .o_rx_overrun (o_rx_overrun)
    );
endmodule : hsp_device_end

// File: core/hsp_host_end.sv
`timescale 1ns/1ps
// host end: same engine, stops sending while device request deasserted
module hsp_host_end
    import hsp_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    // link
    hsp_link_if.host        link,
    // user streams
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    input  wire logic       i_rx_ready,
    output logic            o_rx_overrun
);
    // permit from device request, never looped locally
    hsp_port_core u_core (
        .i_ref_clk    (i_ref_clk),
        .i_rst_b      (i_rst_b),
        .i_ce         (i_ce),
        .i_ir_mode    (1'b0),
        .i_rx_line    (link.dev_tx),
        .i_permit_n   (link.dev_req_n),
        .o_tx_line    (link.host_tx),
        .o_tx_drive   (),
        .o_req_n      (link.host_req_n),
        .i_tx_valid   (i_tx_valid),
        .i_tx_data    (i_tx_data),
        .o_tx_ready   (o_tx_ready),
        .o_rx_valid   (o_rx_valid),
        .o_rx_data    (o_rx_data),
        .i_rx_ready   (i_rx_ready),
        .o_rx_overrun (o_rx_overrun)
    );
endmodule : hsp_host_end

// File: core/hsp_link_if.sv
`timescale 1ns/1ps
// crossed serial link with active-low handshake between device and host
interface hsp_link_if;
    logic dev_tx;     // device serial out -> host receive
    logic host_tx;    // host transmit -> device serial in
    logic dev_req_n;  // device flow request out, active low
    logic host_req_n; // host request, fed to device flow permit in

    modport device (output dev_tx, output dev_req_n, input host_tx, input host_req_n);
    modport host   (input dev_tx, input dev_req_n, output host_tx, output host_req_n);
endinterface : hsp_link_if

// File: core/hsp_pkg.sv
package hsp_pkg;
    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    // serial engine phases
    typedef enum logic [1:0] {HSP_IDLE, HSP_START, HSP_DATA, HSP_STOP} hsp_phase_e;

    // bit timer and bit index types
    typedef logic [15:0] hsp_cnt_t;
    typedef logic [2:0]  hsp_idx_t;
    typedef logic [7:0]  hsp_byte_t;

    // both directions of a serial engine plus its two-entry receive buffer
    typedef struct packed {
        hsp_phase_e tx_ph;
        hsp_cnt_t   tx_cnt;
        hsp_idx_t   tx_idx;
        hsp_byte_t  tx_sh;
        logic       tx_line;
        hsp_phase_e rx_ph;
        hsp_cnt_t   rx_cnt;
        hsp_idx_t   rx_idx;
        hsp_byte_t  rx_sh;
        logic       rx_s1;
        logic       rx_s2;
        hsp_byte_t  buf0;
        hsp_byte_t  buf1;
        logic [1:0] fill;
        logic       ovr;
        logic       req_n;
    } hsp_state_s;
endpackage : hsp_pkg

// File: core/hsp_port_core.sv
`timescale 1ns/1ps
`include "hsp_defs.svh"
// shared serial engine: transmitter, receiver, two-entry receive buffer
module hsp_port_core
    import hsp_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    // mode
    input  wire logic       i_ir_mode,
    // line
    input  wire logic       i_rx_line,
    input  wire logic       i_permit_n,
    output logic            o_tx_line,
    output logic            o_tx_drive,
    output logic            o_req_n,
    // transmit stream
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    // receive stream
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    input  wire logic       i_rx_ready,
    output logic            o_rx_overrun
);
    localparam hsp_cnt_t BIT = hsp_cnt_t'(`HSP_BIT_CYC);
    localparam hsp_cnt_t HALF = hsp_cnt_t'(`HSP_BIT_CYC / 2);
    localparam hsp_cnt_t IRC = hsp_cnt_t'(`HSP_IR_CYC);

    hsp_state_s s_reg;  // all state
    hsp_state_s s_next; // next state
    logic       push;   // receiver delivers a byte
    logic       pop;    // consumer takes head

    assign o_tx_ready   = (s_reg.tx_ph == HSP_IDLE) && (i_permit_n == `HSP_HS_ASSERT);
    assign o_rx_valid   = (s_reg.fill != 2'h0);
    assign o_rx_data    = s_reg.buf0;
    assign o_req_n      = s_reg.req_n;
    assign o_rx_overrun = s_reg.ovr;
    assign o_tx_drive   = (s_reg.tx_ph != HSP_IDLE);
    // infrared: a short low pulse only for zero bits, line otherwise high
    assign o_tx_line    = i_ir_mode ? ~(~s_reg.tx_line && (s_reg.tx_cnt < IRC))
                                    : s_reg.tx_line;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        push   = 1'b0;
        pop    = o_rx_valid && i_rx_ready;
        // input synchroniser, first stage read only by second
        s_next.rx_s1 = i_rx_line;
        s_next.rx_s2 = s_reg.rx_s1;
        // transmitter; new character only while permit asserted
        case (s_reg.tx_ph)
            HSP_IDLE:
            begin
                s_next.tx_line = `HSP_LINE_IDLE;
                if (i_tx_valid && o_tx_ready)
                begin
                    s_next.tx_sh   = i_tx_data;
                    s_next.tx_ph   = HSP_START;
                    s_next.tx_line = 1'b0;
                    s_next.tx_cnt  = '0;
                end
            end
            default:
            begin
                s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
                if (s_reg.tx_cnt == BIT - 16'h0001)
                begin
                    s_next.tx_cnt = '0;
                    case (s_reg.tx_ph)
                        HSP_START:
                        begin
                            s_next.tx_ph   = HSP_DATA;
                            s_next.tx_idx  = '0;
                            s_next.tx_line = s_reg.tx_sh[0];
                        end
                        HSP_DATA:
                        begin
                            s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
                            s_next.tx_idx = s_reg.tx_idx + 3'h1;
                            if (s_reg.tx_idx == 3'h7)
                            begin
                                s_next.tx_ph   = HSP_STOP;
                                s_next.tx_line = 1'b1;
                            end
                            else
                            begin
                                s_next.tx_line = s_reg.tx_sh[1];
                            end
                        end
                        default:
                        begin
                            s_next.tx_ph = HSP_IDLE;
                        end
                    endcase
                end
            end
        endcase
        // receiver, samples mid-bit
        case (s_reg.rx_ph)
            HSP_IDLE:
            begin
                s_next.rx_cnt = '0;
                if (!s_reg.rx_s2)
                begin
                    s_next.rx_ph = HSP_START;
                end
            end
            HSP_START:
            begin
                s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
                if (s_reg.rx_cnt == HALF)
                begin
                    s_next.rx_cnt = '0;
                    s_next.rx_idx = '0;
                    s_next.rx_ph  = s_reg.rx_s2 ? HSP_IDLE : HSP_DATA;
                end
            end
            HSP_DATA:
            begin
                s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
                if (s_reg.rx_cnt == BIT - 16'h0001)
                begin
                    s_next.rx_cnt = '0;
                    s_next.rx_sh  = {s_reg.rx_s2, s_reg.rx_sh[7:1]};
                    s_next.rx_idx = s_reg.rx_idx + 3'h1;
                    if (s_reg.rx_idx == 3'h7)
                    begin
                        s_next.rx_ph = HSP_STOP;
                    end
                end
            end
            default:
            begin
                s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
                if (s_reg.rx_cnt == BIT - 16'h0001)
                begin
                    s_next.rx_ph = HSP_IDLE;
                    push         = s_reg.rx_s2;  // framing error drops byte
                end
            end
        endcase
        // two-entry buffer; overflow sets a sticky flag, byte lost
        if (pop)
        begin
            s_next.buf0 = s_reg.buf1;
            s_next.fill = s_reg.fill - 2'h1;
        end
        if (push)
        begin
            if (s_next.fill == 2'h0)
            begin
                s_next.buf0 = s_reg.rx_sh;
                s_next.fill = 2'h1;
            end
            else if (s_next.fill == 2'h1)
            begin
                s_next.buf1 = s_reg.rx_sh;
                s_next.fill = 2'h2;
            end
            else
            begin
                s_next.ovr = 1'b1;
            end
        end
        // request asserted only while room for a full entry remains
        s_next.req_n = (s_next.fill == 2'h2) ? `HSP_HS_DEASSERT : `HSP_HS_ASSERT;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_reg         <= '0;
            s_reg.tx_line <= `HSP_LINE_IDLE;
            s_reg.rx_s1   <= 1'b1;
            s_reg.rx_s2   <= 1'b1;
            s_reg.req_n   <= `HSP_HS_ASSERT;
        end
        else if (i_ce)
        begin
            s_reg <= s_next;
        end
    end
endmodule : hsp_port_core

// File: verification/hsp_link_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------
// link checker: framing and handshake on the wires
// ------------------------------------------------
module hsp_link_properties (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic dev_tx,
    input wire logic host_tx,
    input wire logic dev_req_n,
    input wire logic host_req_n
);
    logic [8:0] dcnt_reg;  // cycle within a device frame
    logic [8:0] hcnt_reg;  // cycle within a host frame
    logic       dprev_reg; // device line one cycle ago
    logic       hprev_reg; // host line one cycle ago

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    // next frame position: starts on a fall from idle, wraps to 0 after 499
    function automatic logic [8:0] nxt(input logic [8:0] c, input logic fell);
        if (c == 9'h1F3)
            return 9'h000;
        if (c != 9'h000 || fell)
            return c + 9'h001;
        return c;
    endfunction : nxt

    // frame position counters
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            dcnt_reg  <= 9'h000;
            hcnt_reg  <= 9'h000;
            dprev_reg <= 1'b1;
            hprev_reg <= 1'b1;
        end
        else
        begin
            dcnt_reg  <= nxt(dcnt_reg, dprev_reg && !dev_tx);
            hcnt_reg  <= nxt(hcnt_reg, hprev_reg && !host_tx);
            dprev_reg <= dev_tx;
            hprev_reg <= host_tx;
        end
    end

    AST_RST_LINES: assert property ($rose(i_rst_b) |-> dev_tx && host_tx && !dev_req_n)
        else $error("lines not at reset level");
    AST_DEV_START: assert property (dcnt_reg != 9'h000 && dcnt_reg < 9'h032 |-> !dev_tx)
        else $error("device start bit short");
    AST_DEV_STOP: assert property (dcnt_reg >= 9'h1C2 |-> dev_tx)
        else $error("device stop bit low");
    AST_DEV_EDGE: assert property (dcnt_reg != 9'h000 && $changed(dev_tx)
        |-> (dcnt_reg % 9'h032) == 9'h000)
        else $error("device line moved inside a bit");
    AST_HOST_START: assert property (hcnt_reg != 9'h000 && hcnt_reg < 9'h032 |-> !host_tx)
        else $error("host start bit short");
    AST_HOST_STOP: assert property (hcnt_reg >= 9'h1C2 |-> host_tx)
        else $error("host stop bit low");
    AST_PERMIT: assert property (dcnt_reg == 9'h000 && dev_tx && host_req_n |=> dev_tx)
        else $error("device sent without permit");
    AST_HOLD: assert property (hcnt_reg == 9'h000 && host_tx && dev_req_n |=> host_tx)
        else $error("host sent without request");
    AST_REQ_RISE: assert property ($rose(dev_req_n)
        |-> hcnt_reg >= 9'h1C2 || hcnt_reg < 9'h008)
        else $error("request dropped outside a frame end");

    // main scenarios reached
    cover property (dcnt_reg == 9'h1F3);
    cover property (hcnt_reg == 9'h1F3);
    cover property ($rose(dev_req_n));
endmodule : hsp_link_properties

// File: verification/tb.sv
`timescale 1ns/1ps
// ------------------------------------------------
// bench: device and host ends facing each other
// ------------------------------------------------
module tb;
    logic       clk;     // reference clock
    logic       rst_b;   // reset, active low
    logic       ce;      // clock enable
    logic       ir;      // infrared select
    logic       txv [2]; // send valid, 0 device 1 host
    logic [7:0] txd [2]; // send data
    logic       txr [2]; // send ready
    logic       rxv [2]; // receive valid
    logic [7:0] rxd [2]; // receive data
    logic       rxr [2]; // receive ready
    logic       ovr [3]; // overrun, 2 is second device
    logic       de;      // line driver enable
    logic       txv2;    // send valid, second device
    logic [7:0] txd2;    // send data, second device
    int         n_fail;  // mismatches
    int         checks;  // comparisons
    hsp_link_if link ();
    hsp_link_if link2 ();

    always #10 clk = ~clk;

    hsp_device_end hsp_device_end_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
        .link(link.device), .i_ir_mode(ir), .o_rs485_de(de), .i_tx_valid(txv[0]),
        .i_tx_data(txd[0]), .o_tx_ready(txr[0]), .o_rx_valid(rxv[0]), .o_rx_data(rxd[0]),
        .i_rx_ready(rxr[0]), .o_rx_overrun(ovr[0]));
    hsp_host_end hsp_host_end_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
        .link(link.host), .i_tx_valid(txv[1]), .i_tx_data(txd[1]), .o_tx_ready(txr[1]),
        .o_rx_valid(rxv[1]), .o_rx_data(rxd[1]), .i_rx_ready(rxr[1]), .o_rx_overrun(ovr[1]));
    // second device fed by a host that ignores the handshake
    hsp_device_end hsp_device_end_i2 (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
        .link(link2.device), .i_ir_mode(ir), .o_rs485_de(), .i_tx_valid(txv2),
        .i_tx_data(txd2), .o_tx_ready(), .o_rx_valid(), .o_rx_data(), .i_rx_ready(1'b0),
        .o_rx_overrun(ovr[2]));
    hsp_link_properties hsp_link_properties_i (.i_ref_clk(clk), .i_rst_b(rst_b),
        .dev_tx(link.dev_tx), .host_tx(link.host_tx), .dev_req_n(link.dev_req_n),
        .host_req_n(link.host_req_n));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask : cmp

    task automatic cmpb(input logic got, input logic exp, input string what);
        cmp({7'h00, got}, {7'h00, exp}, what);
    endtask : cmpb

    // wait for ready, release valid after the taking edge
    task automatic await_take(input int e);
        for (int n = 0; n < 3000 && txr[e] !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        txv[e] <= 1'b0;
    endtask : await_take

    task automatic send(input int e, input logic [7:0] b);
        @(posedge clk);
        txv[e] <= 1'b1;
        txd[e] <= b;
        @(negedge clk);
        await_take(e);
    endtask : send

    task automatic recv(input int e, input logic [7:0] b);
        for (int n = 0; n < 3000; n++)
        begin
            @(negedge clk);
            if (rxv[e] === 1'b1)
                break;
        end
        cmp(rxd[e], b, "received byte");
    endtask : recv

    // mid-bit samples of one frame, lsb first
    task automatic wire_chk(input int e, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            repeat (i == 0 ? 25 : 50) @(negedge clk);
            cmpb(e ? link.host_tx : link.dev_tx, f[i], "line bit");
            if (e == 0 && i == 4) cmpb(de, 1'b1, "driver enable");
        end
    endtask : wire_chk

    // receiver e stalls, fills two entries, sender must hold the third
    task automatic t_flow(input int e, input logic [7:0] a, b, c);
        @(posedge clk);
        rxr[e] <= 1'b0;
        send(1 - e, a);
        wire_chk(1 - e, a);
        send(1 - e, b);
        repeat (600) @(negedge clk);
        @(posedge clk);
        txv[1 - e] <= 1'b1;
        txd[1 - e] <= c;
        repeat (600) @(negedge clk);
        cmpb(e ? link.host_req_n : link.dev_req_n, 1'b1, "request level");
        cmpb(txr[1 - e], 1'b0, "sender held");
        cmpb(e ? link.dev_tx : link.host_tx, 1'b1, "idle line");
        cmpb(ovr[e], 1'b0, "overrun");
        cmp(rxd[e], a, "head byte");
        @(posedge clk);
        rxr[e] <= 1'b1;
        @(posedge clk);
        rxr[e] <= 1'b0;
        await_take(1 - e);
        @(posedge clk);
        rxr[e] <= 1'b1;
        recv(e, b);
        recv(e, c);
        $display("test flow %0d done", e);
    endtask : t_flow

    // infrared pulses on the second device, then a clock-enable freeze mid pulse
    task automatic t_ir();
        @(posedge clk);
        ir <= 1'b1;
        txv2 <= 1'b1;
        txd2 <= 8'hFE;
        @(posedge clk);
        txv2 <= 1'b0;
        repeat (4) @(negedge clk);
        cmpb(link2.dev_tx, 1'b0, "ir start pulse");
        repeat (21) @(negedge clk);
        cmpb(link2.dev_tx, 1'b1, "ir after pulse");
        repeat (29) @(negedge clk);
        cmpb(link2.dev_tx, 1'b0, "ir zero bit pulse");
        @(posedge clk);
        ce <= 1'b0;
        repeat (100) @(negedge clk);
        cmpb(link2.dev_tx, 1'b0, "frozen by enable");
        @(posedge clk);
        ce <= 1'b1;
        repeat (500) @(posedge clk);
        ir <= 1'b0;
        @(negedge clk);
        cmpb(link2.dev_tx, 1'b1, "ir idle line");
        $display("test infrared done");
    endtask : t_ir

    task automatic t_overrun();
        logic [9:0] f;
        @(posedge clk);
        for (int k = 0; k < 3; k++)
        begin
            f = {1'b1, 8'h81 + k[7:0], 1'b0};
            for (int i = 0; i < 10; i++)
            begin
                link2.host_tx <= f[i];
                repeat (50) @(posedge clk);
            end
        end
        repeat (20) @(posedge clk);
        cmpb(ovr[2], 1'b1, "overrun");
        cmpb(link2.dev_req_n, 1'b1, "request level");
        $display("test overrun done");
    endtask : t_overrun

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        ir = 1'b0;
        txv = '{1'b0, 1'b0};
        txd = '{8'h00, 8'h00};
        rxr = '{1'b1, 1'b1};
        txv2 = 1'b0;
        txd2 = 8'h00;
        n_fail = 0;
        checks = 0;
        link2.host_tx = 1'b1;
        link2.host_req_n = 1'b0;
        repeat (5) @(posedge clk);
        cmpb(link.dev_tx, 1'b1, "idle line");
        cmpb(link.host_tx, 1'b1, "idle line");
        cmpb(link.dev_req_n, 1'b0, "request");
        rst_b <= 1'b1;
        $display("test reset done");
        t_flow(0, 8'h3C, 8'hC3, 8'h5A);
        t_flow(1, 8'h44, 8'h81, 8'h7E);
        t_ir();
        t_overrun();
        give_verdict();
    end

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("unexpected at %0t: run hung", $time);
        give_verdict();
    end
endmodule : tb
